// file: include/bbs_pkg.sv
// Constants and types for the buck-boost supervisor
package bbs_pkg;
  localparam logic [6:0] TGT_ADDR   = 7'h75;
  localparam logic [7:0] OFS_CTRL   = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_ID     = 8'h03;
  localparam logic [7:0] OFS_FIRST  = 8'h04;
  localparam logic [7:0] OFS_SECOND = 8'h05;
  localparam logic [7:0] CTRL_RST   = 8'h20;
  localparam logic [7:0] CTRL_WMASK = 8'h23;
  localparam logic [7:0] TGT_WMASK  = 8'h7f;
  localparam logic [7:0] FIRST_RST  = 8'h00;
  localparam logic [7:0] SECOND_RST = 8'h00;
  // Identity value is arbitrary
  localparam logic [7:0] ID_VALUE   = 8'h5a;
  localparam int CTRL_EN_BIT = 5;
  localparam int SLEW_LSB    = 0;
  localparam int ST_NGOOD    = 0;
  localparam int ST_OVH      = 1;
  localparam int ST_SHORT    = 2;
  localparam int ST_OVV      = 3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_REG  = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  localparam int CLK_NS   = 10;
  localparam int STEP_UV  = 25000;
  localparam int STEP_W   = 12;
  // Step period per slew setting: 1, 2.5, 5, 10 V/ms (uV per us)
  localparam logic [STEP_W-1:0] SLEW_CYC [4] = '{
    STEP_W'(STEP_UV * 1000 / 1000 / CLK_NS),
    STEP_W'(STEP_UV * 1000 / 2500 / CLK_NS),
    STEP_W'(STEP_UV * 1000 / 5000 / CLK_NS),
    STEP_W'(STEP_UV * 1000 / 10000 / CLK_NS)};
  localparam int HIC_ON_US   = 180;
  localparam int HIC_OFF_US  = 2000;
  localparam int HIC_ON_CYC  = HIC_ON_US * 1000 / CLK_NS;
  localparam int HIC_OFF_CYC = HIC_OFF_US * 1000 / CLK_NS;
  localparam int HIC_W       = 18;
  localparam int PIN_SCL = 0, PIN_SDA = 1, PIN_EN = 2, PIN_SEL = 3;
  localparam int PIN_LOCK = 4, PIN_OVV = 5, PIN_HOT = 6, PIN_COOL = 7;
  localparam int PIN_UP = 8, PIN_DN = 9, PIN_SHORT = 10, PIN_N = 11;
  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_TXACK,
                            I2C_SKIP} bbs_i2c_t;
  typedef enum logic [1:0] {HIC_RUN, HIC_ON, HIC_OFF} bbs_hic_t;
endpackage : bbs_pkg

// file: hw/bbs_supervisor.sv
// Supervisor logic and I2C register target of the buck-boost regulator
// How it works
// R1: Select change or active write starts ramp
// R2: Before first power-good, new target applies at once
// R3: Supply overvoltage stops switching, auto resume
// R4: Overvoltage forces power-not-good flag high
// R5: Overheat shuts off, restarts once cooled
// R6: Register target works during overheat shutdown
// R7: Overheat bit sticky, read clears only when cool
// R8: Active-low power-good in status, 95/90 hysteresis
// R9: Shutdown isolates input from output
// R10: Short runs hiccup: 180us limited, 2ms off
// R11: Enable pin or bit low discharges output
// R12: On mode needs supply above lockout, enable high
// R13: Answer only 7-bit address 75h
// R14: One protocol for all bus rates
// R15: Five 8-bit registers, read-only bits protected
// R16: Registers kept while supply stays up and enable pin high
// R17: Host sends STOP after bus power-up
// R18: Host starts on idle bus, ends with STOP
// R19: Select low uses first, high second setting
// R20: Ramp steps 25mV at slew-field pace
// R21: Status read clears bits unless still present
// R22: Foreign address gets no acknowledge, ignored
`timescale 1ns/1ns
module bbs_supervisor
  import bbs_pkg::*;
#(
  parameter int HIC_ON_CYCLES  = HIC_ON_CYC,
  parameter int HIC_OFF_CYCLES = HIC_OFF_CYC
)
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       enPin,
  input  wire logic       targetSelectPin,
  input  wire logic       lowSupplyLockout,
  input  wire logic       supplyOvervoltGuard,
  input  wire logic       tempAbove150,
  input  wire logic       tempBelow130,
  input  wire logic       outAbove95,
  input  wire logic       outBelow90,
  input  wire logic       outShort,
  output logic            switchEnable,
  output logic            hiccupLimit,
  output logic            dischargeOn,
  output logic            isolateOn,
  output logic [6:0]      targetCode,
  output logic            rampBusy,
  output logic            powerNotGoodFlag,
  output logic            overheatFlag
);
  logic [PIN_N-1:0] pinMeta_r;
  logic [PIN_N-1:0] pinSync_r;
  logic             sclPrev_r;
  logic             sdaPrev_r;
  logic             selPrev_r;
  logic             sclNow, sdaNow, sclRise, sclFall, startSeen, stopSeen;
  logic             enS, selS, lockS, ovvS, hotS, coolS, upS, dnS, shortS;
  logic             regClr, onMode, active, selChg, actWrite;

  bbs_i2c_t         st_r, st_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic [1:0]       ph_r, ph_nxt;
  logic             rd_r, rd_nxt;
  logic [7:0]       ptr_r, ptr_nxt;
  logic             oe_r, oe_nxt;
  logic [7:0]       first_r, first_nxt;
  logic [7:0]       second_r, second_nxt;
  logic [7:0]       ctrl_r, ctrl_nxt;
  logic [7:0]       status_r, status_nxt;
  logic             wrFirst, wrSecond, rdStatus, loadTx;
  logic [7:0]       rdData;

  bbs_hic_t         hic_r, hic_nxt;
  logic [HIC_W-1:0] hicCnt_r, hicCnt_nxt;
  logic [STEP_W-1:0] slewCnt_r, slewCnt_nxt;
  logic [6:0]       tgt_r, tgt_nxt, finalCode;
  logic             ovhShut_r, ovhShut_nxt;
  logic             pgood_r, pgood_nxt;
  logic             firstGood_r, firstGood_nxt;
  logic             sw_r, sw_nxt;
  logic             lim_r, lim_nxt;
  logic             dis_r, dis_nxt;
  logic             iso_r, iso_nxt;
  logic             busy_r, busy_nxt;
  logic             notGood_r, notGood_nxt;

  // Two-stage synchronisers for every pin
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      selPrev_r <= 1'b0;
    end
    else
    begin
      pinMeta_r <= {outShort, outBelow90, outAbove95, tempBelow130,
                    tempAbove150, supplyOvervoltGuard, lowSupplyLockout,
                    targetSelectPin, enPin, sdaIn, sclIn};
      pinSync_r <= pinMeta_r;
      sclPrev_r <= pinSync_r[PIN_SCL];
      sdaPrev_r <= pinSync_r[PIN_SDA];
      selPrev_r <= pinSync_r[PIN_SEL];
    end
  end

  assign sclNow    = pinSync_r[PIN_SCL];
  assign sdaNow    = pinSync_r[PIN_SDA];
  assign enS       = pinSync_r[PIN_EN];
  assign selS      = pinSync_r[PIN_SEL];
  assign lockS     = pinSync_r[PIN_LOCK];
  assign ovvS      = pinSync_r[PIN_OVV];
  assign hotS      = pinSync_r[PIN_HOT];
  assign coolS     = pinSync_r[PIN_COOL];
  assign upS       = pinSync_r[PIN_UP];
  assign dnS       = pinSync_r[PIN_DN];
  assign shortS    = pinSync_r[PIN_SHORT];
  // Edge-based bus sampling works the same at every bus rate
  assign sclRise   = sclNow & ~sclPrev_r; // R14
  assign sclFall   = ~sclNow & sclPrev_r;
  assign startSeen = sclNow & sclPrev_r & sdaPrev_r & ~sdaNow;
  assign stopSeen  = sclNow & sclPrev_r & ~sdaPrev_r & sdaNow;
  // Registers fall back to defaults only on reset, lockout or enable pin low
  assign regClr    = lockS | ~enS; // R16
  assign onMode    = ~lockS & enS; // R12
  assign active    = onMode & ctrl_r[CTRL_EN_BIT];

  always_comb
  begin
    rdData = 8'h00;
    if (ptr_r == OFS_CTRL)
      rdData = ctrl_r;
    else if (ptr_r == OFS_STATUS)
      rdData = status_r;
    else if (ptr_r == OFS_ID)
      rdData = ID_VALUE;
    else if (ptr_r == OFS_FIRST)
      rdData = first_r;
    else if (ptr_r == OFS_SECOND)
      rdData = second_r;
  end

  // Bus target and register bank; runs regardless of converter state
  always_comb
  begin // R6
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ph_nxt = ph_r;
    rd_nxt = rd_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    first_nxt = first_r;
    second_nxt = second_r;
    ctrl_nxt = ctrl_r;
    wrFirst = 1'b0;
    wrSecond = 1'b0;
    loadTx = 1'b0;
    if (stopSeen)
    begin
      st_nxt = I2C_IDLE;
      oe_nxt = 1'b0;
    end
    else if (startSeen)
    begin
      st_nxt = I2C_RX;
      ph_nxt = PH_ADDR;
      cnt_nxt = '0;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        I2C_RX:
          if (sclRise)
          begin
            sh_nxt = {sh_r[6:0], sdaNow};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (sclFall && cnt_r == BYTE_BITS)
          begin
            if (ph_r == PH_ADDR)
            begin
              if (sh_r[7:1] == TGT_ADDR)
              begin // R13
                st_nxt = I2C_ACK;
                oe_nxt = 1'b1;
                rd_nxt = sh_r[0];
              end
              else
                st_nxt = I2C_SKIP; // R22
            end
            else
            begin
              st_nxt = I2C_ACK;
              oe_nxt = 1'b1;
              if (ph_r == PH_REG)
                ptr_nxt = sh_r;
              else
              begin
                ptr_nxt = ptr_r + 8'h01;
                if (ptr_r == OFS_FIRST)
                begin
                  first_nxt = sh_r & TGT_WMASK; // R15
                  wrFirst = 1'b1;
                end
                else if (ptr_r == OFS_SECOND)
                begin
                  second_nxt = sh_r & TGT_WMASK;
                  wrSecond = 1'b1;
                end
                else if (ptr_r == OFS_CTRL)
                  ctrl_nxt = (ctrl_r & ~CTRL_WMASK) | (sh_r & CTRL_WMASK);
              end
            end
          end
        I2C_ACK:
          if (sclFall)
          begin
            cnt_nxt = '0;
            if (rd_r && ph_r == PH_ADDR)
              loadTx = 1'b1;
            else
            begin
              st_nxt = I2C_RX;
              oe_nxt = 1'b0;
              ph_nxt = (ph_r == PH_ADDR) ? PH_REG : PH_DATA;
            end
          end
        I2C_TX:
          if (sclRise)
            cnt_nxt = cnt_r + 4'h1;
          else if (sclFall)
          begin
            if (cnt_r == BYTE_BITS)
            begin
              st_nxt = I2C_TXACK;
              oe_nxt = 1'b0;
            end
            else
            begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        I2C_TXACK:
          if (sclRise)
          begin
            st_nxt = sdaNow ? I2C_SKIP : I2C_TXACK;
            cnt_nxt = '0;
          end
          else if (sclFall && cnt_r == '0)
            loadTx = 1'b1;
        default:
        begin
        end
      endcase
    end
    if (loadTx)
    begin
      st_nxt = I2C_TX;
      sh_nxt = rdData;
      oe_nxt = ~rdData[7];
      ptr_nxt = ptr_r + 8'h01;
    end
  end

  assign rdStatus = loadTx && ptr_r == OFS_STATUS;

  // Sticky events; a set in the clearing cycle wins
  always_comb
  begin
    status_nxt = status_r;
    if (rdStatus)
    begin
      status_nxt[ST_SHORT] = 1'b0; // R21
      status_nxt[ST_OVV] = 1'b0;
      if (coolS)
        status_nxt[ST_OVH] = 1'b0; // R7
    end
    if (hotS)
      status_nxt[ST_OVH] = 1'b1; // R7
    if (shortS)
      status_nxt[ST_SHORT] = 1'b1; // R21
    if (ovvS)
      status_nxt[ST_OVV] = 1'b1;
    status_nxt[ST_NGOOD] = notGood_nxt; // R8
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= I2C_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      ph_r <= PH_ADDR;
      rd_r <= 1'b0;
      ptr_r <= '0;
      oe_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ph_r <= ph_nxt;
      rd_r <= rd_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
    end
    if (!reset_n || regClr)
    begin
      first_r <= FIRST_RST;
      second_r <= SECOND_RST;
      ctrl_r <= CTRL_RST;
      status_r <= 8'h00;
    end
    else
    begin
      first_r <= first_nxt;
      second_r <= second_nxt;
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
    end
  end

  assign finalCode = selS ? second_r[6:0] : first_r[6:0]; // R19
  assign selChg    = selS != selPrev_r;
  assign actWrite  = selS ? wrSecond : wrFirst;

  // Converter supervision
  always_comb
  begin
    ovhShut_nxt = ovhShut_r;
    if (hotS)
      ovhShut_nxt = 1'b1; // R5
    else if (coolS)
      ovhShut_nxt = 1'b0;
    pgood_nxt = pgood_r;
    if (!active)
      pgood_nxt = 1'b0;
    else if (upS)
      pgood_nxt = 1'b1; // R8
    else if (dnS)
      pgood_nxt = 1'b0;
    firstGood_nxt = active & (firstGood_r | pgood_r);
    tgt_nxt = tgt_r;
    slewCnt_nxt = slewCnt_r;
    if (!firstGood_r)
      tgt_nxt = finalCode; // R2
    else if (selChg || actWrite)
      slewCnt_nxt = '0; // R1
    else if (tgt_r != finalCode)
    begin
      if (slewCnt_r >= SLEW_CYC[ctrl_r[SLEW_LSB+:2]] - STEP_W'(1))
      begin
        slewCnt_nxt = '0;
        tgt_nxt = (tgt_r < finalCode) ? tgt_r + 7'h01 : tgt_r - 7'h01; // R20
      end
      else
        slewCnt_nxt = slewCnt_r + STEP_W'(1);
    end
    hic_nxt = hic_r;
    hicCnt_nxt = hicCnt_r + HIC_W'(1);
    case (hic_r)
      HIC_RUN:
        if (shortS && sw_r)
        begin
          hic_nxt = HIC_ON; // R10
          hicCnt_nxt = '0;
        end
      HIC_ON:
        if (hicCnt_r == HIC_W'(HIC_ON_CYCLES - 1))
        begin
          hic_nxt = shortS ? HIC_OFF : HIC_RUN; // R10
          hicCnt_nxt = '0;
        end
      HIC_OFF:
        if (hicCnt_r == HIC_W'(HIC_OFF_CYCLES - 1))
        begin
          hic_nxt = HIC_ON;
          hicCnt_nxt = '0;
        end
      default:
        hic_nxt = HIC_RUN;
    endcase
    if (!active)
      hic_nxt = HIC_RUN;
    sw_nxt = active & ~ovvS & ~ovhShut_r & (hic_r != HIC_OFF); // R3
    lim_nxt = hic_r == HIC_ON; // R10
    dis_nxt = ~enS | ~ctrl_r[CTRL_EN_BIT]; // R11
    iso_nxt = ~sw_nxt; // R9
    busy_nxt = tgt_nxt != finalCode;
    notGood_nxt = ~pgood_r | ovvS; // R4
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      hic_r <= HIC_RUN;
      hicCnt_r <= '0;
      slewCnt_r <= '0;
      tgt_r <= '0;
      ovhShut_r <= 1'b0;
      pgood_r <= 1'b0;
      firstGood_r <= 1'b0;
      sw_r <= 1'b0;
      lim_r <= 1'b0;
      dis_r <= 1'b1;
      iso_r <= 1'b1;
      busy_r <= 1'b0;
      notGood_r <= 1'b1;
    end
    else
    begin
      hic_r <= hic_nxt;
      hicCnt_r <= hicCnt_nxt;
      slewCnt_r <= slewCnt_nxt;
      tgt_r <= tgt_nxt;
      ovhShut_r <= ovhShut_nxt;
      pgood_r <= pgood_nxt;
      firstGood_r <= firstGood_nxt;
      sw_r <= sw_nxt;
      lim_r <= lim_nxt;
      dis_r <= dis_nxt;
      iso_r <= iso_nxt;
      busy_r <= busy_nxt;
      notGood_r <= notGood_nxt;
    end
  end

  assign sdaOut           = 1'b0;
  assign sdaOe            = oe_r;
  assign switchEnable     = sw_r;
  assign hiccupLimit      = lim_r;
  assign dischargeOn      = dis_r;
  assign isolateOn        = iso_r;
  assign targetCode       = tgt_r;
  assign rampBusy         = busy_r;
  assign powerNotGoodFlag = notGood_r;
  assign overheatFlag     = status_r[ST_OVH];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_addr_match;
    st_r == I2C_RX && ph_r == PH_ADDR && sclFall && cnt_r == BYTE_BITS
      && sh_r[7:1] == TGT_ADDR && !startSeen && !stopSeen;
  endsequence
  sequence s_still_starting;
    !firstGood_r ##1 !firstGood_r;
  endsequence
  property p_ovv_stop;
    ovvS |=> !sw_r;
  endproperty
  property p_ovv_flag;
    ovvS |=> notGood_r;
  endproperty
  property p_ovh_off;
    hotS |=> ##1 !sw_r && ovhShut_r;
  endproperty
  property p_ovh_keep;
    rdStatus && status_r[ST_OVH] && !coolS && !regClr |=> status_r[ST_OVH];
  endproperty
  property p_addr_ack;
    s_addr_match |=> oe_r && st_r == I2C_ACK;
  endproperty
  property p_skip_quiet;
    st_r == I2C_SKIP |-> !oe_r;
  endproperty
  property p_soft_jump;
    s_still_starting |-> tgt_r == $past(finalCode);
  endproperty
  property p_step_one;
    firstGood_r && $past(firstGood_r) && $changed(tgt_r)
      |-> 7'(tgt_r - $past(tgt_r)) == 7'h01
        || 7'($past(tgt_r) - tgt_r) == 7'h01;
  endproperty
  property p_hic_limit;
    hic_r == HIC_ON |=> lim_r;
  endproperty
  property p_discharge;
    !enS |=> dis_r;
  endproperty
  property p_isolate;
    !onMode |=> iso_r && !sw_r;
  endproperty

  a_ovv_stop: assert property (p_ovv_stop) // R3
    else $error("switching on in overvoltage");
  a_ovv_flag: assert property (p_ovv_flag) // R4
    else $error("not-good flag low in overvoltage");
  a_ovh_off: assert property (p_ovh_off) // R5
    else $error("no overheat stop");
  a_ovh_keep: assert property (p_ovh_keep) // R7
    else $error("hot flag cleared");
  a_addr_ack: assert property (p_addr_ack) // R13
    else $error("own address no ack");
  a_skip_quiet: assert property (p_skip_quiet) // R22
    else $error("sda driven");
  a_soft_jump: assert property (p_soft_jump) // R2
    else $error("ramp in startup");
  a_step_one: assert property (p_step_one) // R20
    else $error("step not 25mV");
  a_hic_limit: assert property (p_hic_limit) // R10
    else $error("no hiccup limit");
  a_discharge: assert property (p_discharge) // R11
    else $error("no discharge");
  a_isolate: assert property (p_isolate) // R9
    else $error("not isolated");
endmodule : bbs_supervisor

// file: verification/bbs_i2c_host.sv
// Behavioural I2C host that reaches the supervisor's registers
`timescale 1ns/1ns
module bbs_i2c_host
  import bbs_pkg::*;
(
  output logic      sclOut,
  output wire logic sdaLine,
  input  wire logic sdaOe,
  input  wire logic sdaOut
);
  logic hostLow = 1'b0;
  int   mul     = 1;
  initial sclOut = 1'b1;
  // Pull-up holds the line high unless a party pulls it low
  assign sdaLine = ~(hostLow | (sdaOe & ~sdaOut));

  task automatic put_bit(input logic b, output logic r);
    #(31 * mul);
    hostLow = ~b;
    #(32 * mul);
    sclOut = 1'b1;
    #(62 * mul);
    r = sdaLine;
    sclOut = 1'b0;
  endtask : put_bit

  // Falling data edge only once both lines have stood high
  task automatic start_cond();
    #(62 * mul);
    hostLow = 1'b0;
    #(31 * mul);
    sclOut = 1'b1;
    #(31 * mul);
    hostLow = 1'b1;
    #(31 * mul);
    sclOut = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #(31 * mul);
    hostLow = 1'b1;
    #(32 * mul);
    sclOut = 1'b1;
    #(62 * mul);
    hostLow = 1'b0;
    #(125 * mul);
  endtask : stop_cond

  task automatic bus_init();
    sclOut = 1'b0;
    stop_cond();
  endtask : bus_init

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask : send_byte

  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(~more, r);
  endtask : get_byte

  // All bytes go out even when refused, so the target must skip them
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] d, output logic ok);
    logic a;
    start_cond();
    send_byte({dev, 1'b0}, ok);
    send_byte(ofs, a);
    send_byte(d, a);
    stop_cond();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start_cond();
    send_byte({TGT_ADDR, 1'b0}, a);
    send_byte(ofs, a);
    start_cond();
    send_byte({TGT_ADDR, 1'b1}, a);
    get_byte(1'b0, d);
    stop_cond();
  endtask : read_reg
endmodule : bbs_i2c_host

// file: verification/buck_boost_supervisor_i2c_tb_top.sv
// Self-checking bench for the buck-boost supervisor
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); \
    end \
  end
module buck_boost_supervisor_i2c_tb_top
  import bbs_pkg::*;
;
  localparam int ON_C  = 20;
  localparam int OFF_C = 50;
  logic       clk = 1'b0, reset_n = 1'b0, enPin = 1'b1, sel = 1'b0;
  logic       lock = 1'b0, ovp = 1'b0, hot = 1'b0, cool = 1'b1;
  logic       up95 = 1'b0, dn90 = 1'b1, shortIn = 1'b0;
  wire        sclLine, sdaLine;
  logic       sdaOut, sdaOe, switchEnable, hiccupLimit, dischargeOn;
  logic       isolateOn, rampBusy, powerNotGoodFlag, overheatFlag;
  logic [6:0] targetCode;
  int         n_mismatch = 0;
  int         check_count = 0;

  always #5 clk = ~clk;

  bbs_supervisor #(.HIC_ON_CYCLES(ON_C), .HIC_OFF_CYCLES(OFF_C)) dut_u (
    .clk(clk), .reset_n(reset_n), .sclIn(sclLine), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .enPin(enPin), .targetSelectPin(sel),
    .lowSupplyLockout(lock), .supplyOvervoltGuard(ovp),
    .tempAbove150(hot), .tempBelow130(cool), .outAbove95(up95),
    .outBelow90(dn90), .outShort(shortIn), .switchEnable(switchEnable),
    .hiccupLimit(hiccupLimit), .dischargeOn(dischargeOn),
    .isolateOn(isolateOn), .targetCode(targetCode), .rampBusy(rampBusy),
    .powerNotGoodFlag(powerNotGoodFlag), .overheatFlag(overheatFlag));

  bbs_i2c_host host_u (.sclOut(sclLine), .sdaLine(sdaLine),
                       .sdaOe(sdaOe), .sdaOut(sdaOut));

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  function automatic logic [7:0] exp_reg(logic [7:0] ofs, logic [7:0] v);
    case (ofs)
      OFS_CTRL:              return v & CTRL_WMASK;
      OFS_FIRST, OFS_SECOND: return v & TGT_WMASK;
      OFS_ID:                return ID_VALUE;
      default:               return 8'h00;
    endcase
  endfunction : exp_reg

  // Ends just after an edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    host_u.write_reg(TGT_ADDR, ofs, d, ok);
    `CHK(ok, 1'b1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] d;
    host_u.read_reg(ofs, d);
    `CHK(d, e);
  endtask : rd_chk

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial
  begin
    #1_000_000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    logic [7:0] v, d, sec;
    logic       ok;
    int         n;
    void'($urandom(35));
    cyc(3);
    `CHK({switchEnable, isolateOn, dischargeOn, powerNotGoodFlag}, 4'h7);
    @(posedge clk) reset_n <= 1'b1;
    cyc(4);
    host_u.bus_init();
    wr(OFS_FIRST, 8'h11);
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'h00 : 8'($urandom_range(127));
      if (v[6:0] == TGT_ADDR)
        v = 8'h76;
      host_u.write_reg(v[6:0], OFS_FIRST, 8'h22, ok);
      `CHK(ok, 1'b0);
    end
    rd_chk(OFS_FIRST, 8'h11);
    rd_chk(OFS_CTRL, CTRL_RST);
    done("address");
    for (int i = 0; i < 15; i++)
    begin
      d = (i % 5 == 0) ? OFS_CTRL : (i % 5 == 1) ? OFS_ID :
          (i % 5 == 2) ? OFS_FIRST : (i % 5 == 3) ? OFS_SECOND : 8'h07;
      v = 8'($urandom);
      if (d == OFS_CTRL)
        v = v | 8'h20;
      wr(d, v);
      rd_chk(d, exp_reg(d, v));
    end
    host_u.mul = 8;
    rd_chk(OFS_ID, ID_VALUE);
    host_u.mul = 20;
    rd_chk(OFS_ID, ID_VALUE);
    host_u.mul = 1;
    done("registers");
    v = 8'($urandom_range(127));
    sec = 8'($urandom_range(120));
    wr(OFS_FIRST, v);
    wr(OFS_SECOND, sec);
    cyc(8);
    `CHK(targetCode, v[6:0]);
    @(posedge clk) sel <= 1'b1;
    cyc(8);
    `CHK(targetCode, sec[6:0]);
    done("startup");
    @(posedge clk) {up95, dn90} <= 2'b10;
    cyc(8);
    `CHK(powerNotGoodFlag, 1'b0);
    @(posedge clk) up95 <= 1'b0;
    cyc(8);
    `CHK(powerNotGoodFlag, 1'b0);
    @(posedge clk) dn90 <= 1'b1;
    cyc(8);
    `CHK(powerNotGoodFlag, 1'b1);
    @(posedge clk) {up95, dn90} <= 2'b10;
    cyc(8);
    host_u.read_reg(OFS_STATUS, d);
    `CHK(d[ST_NGOOD], 1'b0);
    done("power good");
    wr(OFS_CTRL, 8'h23);
    wr(OFS_SECOND, sec + 8'h03);
    `CHK({rampBusy, targetCode}, {1'b1, sec[6:0]});
    cyc(250);
    `CHK(targetCode, sec[6:0] + 7'h01);
    cyc(520);
    `CHK({rampBusy, targetCode}, {1'b0, sec[6:0] + 7'h03});
    wr(OFS_FIRST, sec + 8'h01);
    @(posedge clk) sel <= 1'b0;
    cyc(8);
    `CHK({rampBusy, targetCode}, {1'b1, sec[6:0] + 7'h03});
    cyc(520);
    `CHK({rampBusy, targetCode}, {1'b0, sec[6:0] + 7'h01});
    done("ramp");
    `CHK(switchEnable, 1'b1);
    @(posedge clk) ovp <= 1'b1;
    cyc(8);
    `CHK({switchEnable, isolateOn, powerNotGoodFlag}, 3'b011);
    for (int i = 0; i < 2; i++)
    begin
      host_u.read_reg(OFS_STATUS, d);
      `CHK(d[ST_OVV], 1'b1);
    end
    @(posedge clk) ovp <= 1'b0;
    cyc(8);
    `CHK({switchEnable, isolateOn, powerNotGoodFlag}, 3'b100);
    host_u.read_reg(OFS_STATUS, d);
    `CHK(d[ST_OVV], 1'b1);
    host_u.read_reg(OFS_STATUS, d);
    `CHK(d[ST_OVV], 1'b0);
    done("overvoltage");
    @(posedge clk) {hot, cool} <= 2'b10;
    cyc(8);
    `CHK({switchEnable, overheatFlag}, 2'b01);
    @(posedge clk) hot <= 1'b0;
    rd_chk(OFS_ID, ID_VALUE);
    for (int i = 0; i < 2; i++)
    begin
      host_u.read_reg(OFS_STATUS, d);
      `CHK({d[ST_OVH], switchEnable}, 2'b10);
    end
    @(posedge clk) cool <= 1'b1;
    cyc(8);
    `CHK({switchEnable, overheatFlag}, 2'b11);
    host_u.read_reg(OFS_STATUS, d);
    cyc(4);
    `CHK({d[ST_OVH], overheatFlag}, 2'b10);
    rd_chk(OFS_SECOND, sec + 8'h03);
    done("overheat");
    @(posedge clk) shortIn <= 1'b1;
    n = 0;
    while (hiccupLimit !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (hiccupLimit === 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    `CHK(n >= ON_C - 1 && n <= ON_C + 1, 1'b1);
    n = 0;
    while (switchEnable === 1'b0 && n < 400)
    begin
      cyc(1);
      n++;
    end
    `CHK(n >= OFF_C - 1 && n <= OFF_C + 1, 1'b1);
    `CHK(hiccupLimit, 1'b1);
    @(posedge clk) shortIn <= 1'b0;
    cyc(ON_C + 10);
    `CHK({hiccupLimit, switchEnable}, 2'b01);
    done("hiccup");
    @(posedge clk) enPin <= 1'b0;
    cyc(8);
    `CHK({switchEnable, dischargeOn, isolateOn}, 3'b011);
    @(posedge clk) enPin <= 1'b1;
    cyc(8);
    `CHK({switchEnable, dischargeOn}, 2'b10);
    rd_chk(OFS_FIRST, FIRST_RST);
    wr(OFS_CTRL, 8'h00);
    cyc(8);
    `CHK({switchEnable, dischargeOn}, 2'b01);
    wr(OFS_CTRL, 8'h20);
    cyc(8);
    `CHK({switchEnable, dischargeOn}, 2'b10);
    @(posedge clk) lock <= 1'b1;
    cyc(8);
    `CHK(switchEnable, 1'b0);
    @(posedge clk) lock <= 1'b0;
    cyc(8);
    `CHK(switchEnable, 1'b1);
    done("enable");
    final_report();
  end
endmodule : buck_boost_supervisor_i2c_tb_top
